// ===== logic/b3vc_pkg.sv
// Purpose: Shared constants and types for the buck3 voltage control register.
// Assumes: 20 MHz clock, byte-wide register port from the device's serial host interface.
// Notes: Voltage values are in millivolts.
package b3vc_pkg;
	localparam logic [7:0] B3VC_ADDR = 8'h18;
	localparam logic [7:0] B3VC_RESET = 8'hBD;
	localparam int B3VC_PSKIP_BIT = 7;
	localparam int B3VC_RSVD_BIT = 6;
	localparam int B3VC_CODE_W = 6;
	localparam logic [5:0] B3VC_CODE_RESET = 6'h3D;
	localparam logic [5:0] B3VC_CODE_FINE_LAST = 6'h19;
	localparam logic [5:0] B3VC_CODE_COARSE_FIRST = 6'h1A;
	localparam logic [11:0] B3VC_MV_BASE = 12'h384;
	localparam logic [11:0] B3VC_MV_FINE_STEP = 12'h019;
	localparam logic [11:0] B3VC_MV_COARSE_BASE = 12'h60E;
	localparam logic [11:0] B3VC_MV_COARSE_STEP = 12'h032;
	localparam int B3VC_CLK_HZ = 20000000;
	localparam int B3VC_BLANK_MS = 5;
	localparam int B3VC_BLANK_CYC = B3VC_CLK_HZ / 1000 * B3VC_BLANK_MS;
	localparam int B3VC_CNT_W = 24;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} b3vc_req_type;

	typedef struct packed {
		logic pulse_skip_enable;
		logic [5:0] buck3_vout_code;
		logic [11:0] target_mv;
	} b3vc_cfg_type;
endpackage

// ===== logic/b3vc_blank.sv
// Purpose: Counts out the monitor blanking interval after each register write.
// Assumes: One clock; i_start is a one-cycle pulse from the same domain.
// Notes: A new start restarts the full interval.
`timescale 1ns/1ps
module b3vc_blank #(
	parameter int CYCLES = 100000
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_start,
	output logic o_active
);
	import b3vc_pkg::*;
	logic [B3VC_CNT_W-1:0] cnt_q;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
		end else if (i_start) begin
			cnt_q <= B3VC_CNT_W'(CYCLES);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_active <= 1'b0;
		end else begin
			o_active <= i_start || (cnt_q > B3VC_CNT_W'(1));
		end
	end
endmodule // b3vc_blank

// ===== logic/b3vc_reg.sv
// Purpose: Buck3 voltage control register with write protection and monitor blanking.
// Assumes: Requests come from the serial host interface logic on the same clock.
// Notes: The unlock sequence itself lives elsewhere; this block sees only its result.
//
// How it works
// [RL1] Register sits at subaddress 18h and resets to BDh.
// [RL2] Writes take effect only while the password protection grants them.
// [RL3] Any accepted write blanks over/under-voltage monitor results for 5 ms.
// [RL4] Bit 7 enables pulse-skip, resets to one; zero forces fixed PWM.
// [RL5] Bits 5..0 hold voltage code, reset 3Dh; bit 6 reads zero.
// [RL6] Codes 0h..19h give 0.900 V upward in 25 mV steps.
// [RL7] Codes 1Ah..3Fh give 1.550 V upward in 50 mV steps.
// [RL8] Power-up code may come from the default-select resistor setting.
// [RL9] Writes to bit 6 are ignored; it always reads zero.
`timescale 1ns/1ps
module b3vc_reg #(
	parameter int BLANK_CYCLES = b3vc_pkg::B3VC_BLANK_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input b3vc_pkg::b3vc_req_type i_req,
	input wire logic i_unlocked,
	input wire logic i_default_select_resistor,
	input wire logic [5:0] i_default_select_resistor_code,
	input wire logic i_ov_raw,
	input wire logic i_uv_raw,
	output logic [7:0] o_rdata,
	output logic o_wr_accepted,
	output b3vc_pkg::b3vc_cfg_type o_cfg,
	output logic o_blanking,
	output logic o_ov_fault,
	output logic o_uv_fault
);
	import b3vc_pkg::*;

	logic pskip_q;
	logic [5:0] code_q;
	logic [1:0] strap_cnt_q;
	logic [1:0] default_select_resistor_sync_q;
	logic [1:0] ov_sync_q;
	logic [1:0] uv_sync_q;
	logic wr_ok;
	logic blank_active;

	function automatic logic [11:0] code_to_mv(input logic [5:0] code);
		logic [11:0] c;
		c = {6'h00, code};
		if (code <= B3VC_CODE_FINE_LAST) begin
			code_to_mv = B3VC_MV_BASE + 12'(c * B3VC_MV_FINE_STEP); // see [RL6]
		end else begin
			code_to_mv = B3VC_MV_COARSE_BASE
				+ 12'((c - {6'h00, B3VC_CODE_COARSE_FIRST}) * B3VC_MV_COARSE_STEP); // see [RL7]
		end
	endfunction

	// Protection is judged at the address decode, so a locked write leaves no trace.
	assign wr_ok = i_req.wr && (i_req.addr == B3VC_ADDR) && i_unlocked; // see [RL1] see [RL2]

	// The strap and monitor comparators are asynchronous to this clock.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			default_select_resistor_sync_q <= 2'h0;
			ov_sync_q <= 2'h0;
			uv_sync_q <= 2'h0;
		end else begin
			default_select_resistor_sync_q <= {default_select_resistor_sync_q[0], i_default_select_resistor};
			ov_sync_q <= {ov_sync_q[0], i_ov_raw};
			uv_sync_q <= {uv_sync_q[0], i_uv_raw};
		end
	end

	// The strap is only trusted once it has crossed both synchroniser stages.
	// A host write closes the window, so a later strap load cannot undo it.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			strap_cnt_q <= 2'h0;
		end else if (wr_ok) begin
			strap_cnt_q <= 2'h3;
		end else if (strap_cnt_q != 2'h3) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pskip_q <= B3VC_RESET[B3VC_PSKIP_BIT]; // see [RL4]
		end else if (wr_ok) begin
			pskip_q <= i_req.wdata[B3VC_PSKIP_BIT]; // see [RL4]
		end
	end

	// The strap is caught once after release; a write in that same cycle still wins.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			code_q <= B3VC_CODE_RESET; // see [RL5]
		end else if (wr_ok) begin
			code_q <= i_req.wdata[B3VC_CODE_W-1:0]; // see [RL5]
		end else if ((strap_cnt_q == 2'h2) && default_select_resistor_sync_q[1]) begin
			code_q <= i_default_select_resistor_code; // see [RL8]
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= B3VC_RESET;
		end else begin
			o_rdata <= {pskip_q, 1'b0, code_q}; // see [RL5] see [RL9]
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wr_accepted <= 1'b0;
		end else begin
			o_wr_accepted <= wr_ok;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cfg <= '{B3VC_RESET[B3VC_PSKIP_BIT], B3VC_CODE_RESET, code_to_mv(B3VC_CODE_RESET)};
		end else begin
			o_cfg <= '{pskip_q, code_q, code_to_mv(code_q)};
		end
	end

	b3vc_blank #(
		.CYCLES(BLANK_CYCLES)
	) u_blank (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_start(wr_ok),
		.o_active(blank_active)
	);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_blanking <= 1'b0;
			o_ov_fault <= 1'b0;
			o_uv_fault <= 1'b0;
		end else begin
			o_blanking <= blank_active || wr_ok; // see [RL3]
			o_ov_fault <= ov_sync_q[1] && !blank_active && !wr_ok; // see [RL3]
			o_uv_fault <= uv_sync_q[1] && !blank_active && !wr_ok; // see [RL3]
		end
	end
endmodule // b3vc_reg

// ===== bench/b3vc_props.sv
// Purpose: Port checks for the buck3 voltage register.
// Assumes: One clock, reset low.
// Notes: Bound beside the design.
`timescale 1ns/1ps
module b3vc_props #(
	parameter int BLANK_CYCLES = 10
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input b3vc_pkg::b3vc_req_type i_req,
	input wire logic i_unlocked,
	input wire logic [7:0] o_rdata,
	input wire logic o_wr_accepted,
	input b3vc_pkg::b3vc_cfg_type o_cfg,
	input wire logic o_blanking,
	input wire logic o_ov_fault,
	input wire logic o_uv_fault
);
	import b3vc_pkg::*;
	logic w;
	assign w = i_req.wr && i_req.addr == B3VC_ADDR && i_unlocked;
	function automatic int mv(logic [5:0] c);
		return c < 26 ? 900 + 25 * c : 250 + 50 * c;
	endfunction
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	acc_pulse_a: assert property (w |=> o_wr_accepted) else $error("no accept");
	no_accept_a: assert property (!w |=> !o_wr_accepted) else $error("bad accept");
	blank_go_a: assert property (w |=> o_blanking) else $error("no blank");
	blank_hold_a: assert property ($rose(o_blanking) |-> o_blanking[*8])
		else $error("blank short");
	fault_mask_a: assert property (o_blanking |-> !o_ov_fault && !o_uv_fault)
		else $error("fault leak");
	rdata_new_a: assert property (w |-> ##2 o_rdata == ($past(i_req.wdata, 2) & 8'hBF))
		else $error("bad rdata");
	rsvd_zero_a: assert property (o_rdata[6] == 1'b0) else $error("bit6 set");
	mv_map_a: assert property (o_cfg.target_mv == mv(o_cfg.buck3_vout_code))
		else $error("bad mv");
	pskip_cfg_a: assert property (w |-> ##2 o_cfg.pulse_skip_enable == $past(i_req.wdata[7], 2))
		else $error("bad pskip");
	cover property (w ##1 w);
	cover property ($fell(o_blanking));
	cover property (i_req.wr && !i_unlocked);
endmodule // b3vc_props
bind b3vc_reg b3vc_props #(.BLANK_CYCLES(BLANK_CYCLES)) u_b3vc_props (.i_clk, .i_rstn,
	.i_req, .i_unlocked, .o_rdata, .o_wr_accepted, .o_cfg, .o_blanking, .o_ov_fault,
	.o_uv_fault);

// ===== bench/b3vc_host.sv
// Purpose: Host model writing the buck3 register.
// Assumes: Writes launch 1 ns after a rising edge.
// Notes: Notes each expected readback in a queue.
`timescale 1ns/1ps
module b3vc_host (
	input wire logic i_clk,
	output b3vc_pkg::b3vc_req_type o_req,
	output logic o_unlocked
);
	import b3vc_pkg::*;
	logic [7:0] exp_q[$];
	initial begin
		o_req = '0;
		o_unlocked = 1'b0;
	end
	// Unlock comes with the write it grants.
	task automatic wr(input logic [7:0] a, d, input logic u);
		@(posedge i_clk);
		#1;
		o_req = '{1'b1, a, d};
		o_unlocked = u;
		if (a == B3VC_ADDR && u) exp_q.push_back(d & 8'hBF);
	endtask
	task automatic idle();
		@(posedge i_clk);
		#1;
		o_req.wr = 1'b0;
	endtask
endmodule // b3vc_host

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the buck3 register.
// Assumes: Blanking shortened to 10 cycles.
// Notes: Each accept pulse is paired with the oldest host note.
`timescale 1ns/1ps
module tb_top;
	import b3vc_pkg::*;
	logic i_clk, i_rstn, i_ov_raw, unl, acc, blk, ovf, uvf;
	logic acc_d = 1'b0;
	logic strap = 1'b0;
	logic [5:0] scode = 6'h05;
	b3vc_req_type req;
	logic [7:0] rdata;
	logic [7:0] t[4] = '{8'h59, 8'h1A, 8'hFF, 8'h40};
	b3vc_cfg_type cfg;
	int mismatches = 0, tests_run = 0, cyc = 0, seed = 32'h07ed;
	b3vc_host u_b3vc_host (.i_clk, .o_req(req), .o_unlocked(unl));
	b3vc_reg #(.BLANK_CYCLES(10)) u_b3vc_reg (.i_clk, .i_rstn, .i_req(req), .i_unlocked(unl),
		.i_default_select_resistor(strap), .i_default_select_resistor_code(scode), .i_ov_raw, .i_uv_raw(1'b0),
		.o_rdata(rdata), .o_wr_accepted(acc), .o_cfg(cfg), .o_blanking(blk),
		.o_ov_fault(ovf), .o_uv_fault(uvf));
	task automatic check(input logic [11:0] s, e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask
	task automatic close_out();
		if (mismatches == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			close_out();
		end
	end
	// Readback stands one cycle after the accept pulse, so compare on the next falling edge.
	always @(negedge i_clk) begin
		if (acc_d === 1'b1) begin
			check(rdata, u_b3vc_host.exp_q.size() ? u_b3vc_host.exp_q.pop_front() : 'x);
		end
		acc_d = acc;
	end
	initial begin
		i_rstn = 1'b0;
		i_ov_raw = 1'b1;
		repeat (8) @(posedge i_clk);
		#1 i_rstn = 1'b1;
		check(rdata, 8'hBD);
		check(cfg.target_mv, 12'hCE4);
		for (int i = 0; i < 24; i++) begin
			u_b3vc_host.wr(8'h18, i < 4 ? t[i] : 8'($random(seed)), 1'b1);
		end
		u_b3vc_host.wr(8'h19, 8'h00, 1'b1);
		u_b3vc_host.wr(8'h18, 8'h00, 1'b0);
		u_b3vc_host.idle();
		for (int i = 0; i < 40 && blk !== 1'b0; i++) @(posedge i_clk);
		repeat (4) @(posedge i_clk);
		#1 check(ovf, 1'b1);
		check(12'(u_b3vc_host.exp_q.size()), 12'h000);
		i_rstn = 1'b0;
		strap = 1'b1;
		#50 check(rdata, 8'hBD);
		check(uvf, 1'b0);
		@(posedge i_clk);
		#1 i_rstn = 1'b1;
		repeat (5) @(posedge i_clk);
		#1 check(rdata, 8'h85);
		check(cfg.buck3_vout_code, 6'h05);
		check(cfg.pulse_skip_enable, 1'b1);
		close_out();
	end
endmodule // tb_top
